// File: pcs_pkg.sv
// Overview of operation
// - Low-power bit forces all MAC-side outputs low except management pins.
// - Low-power mode tristates both twisted-pair transmit outputs.
// - Entering low-power keeps registers but resets latching status bits.
// - Any reset loads every register bit with its default value.
// - Isolate floats MII outputs and ignores MII inputs.
// - Isolate never affects the management register access path.
// - Isolate resets to one when strapped PHY address is zero.
// - Restart writes are ignored while auto-negotiation is disabled.
// - Restart bit starts negotiation and clears itself once begun.
// - Hardware mode takes duplex from the duplex select pin.
// - Software mode with negotiation uses the negotiated duplex.
// - Software mode without negotiation uses duplex bit directly, except in loopback.
// - Loopback mode ignores the duplex bit.
// - Collision test off: COL does not follow TXEN.
// - Collision test on: COL follows TXEN, even in loopback.
// - Reserved control bits 6:0 always read zero.
// - Status bit 15 (T4 ability) always reads zero.
// - Status bits 3 and 0 always read one.
// - Negotiation-complete status bit is latching-high, reset zero.
// - Remote-fault status bit is latching-high, reset zero.
// - Software mode without negotiation: rate bit and, outside loopback, duplex bit select mode.
package pcs_pkg;
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PHY_ADDR_ISOLATE = 5'h00;
  // Control bit positions
  localparam int CTL_LOOPBACK = 14;
  localparam int CTL_RATE = 13;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_LOW_POWER = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;
  localparam logic [15:0] CTL_RESET_VAL = 16'h3000;
  // Status bit positions
  localparam int STS_T4 = 15;
  localparam int STS_AN_DONE = 5;
  localparam int STS_RFAULT = 4;
  localparam int STS_AN_ABLE = 3;
  localparam int STS_LINK = 2;
  localparam int STS_JABBER = 1;
  localparam int STS_EXT_CAP = 0;
  localparam logic [15:0] STS_RESET_VAL = 16'h7809;
  localparam logic [15:0] STS_OVR_MASK = 16'h7fc0;
  localparam logic [15:0] STS_LATCH_MASK = 16'h0036;
  localparam logic [15:0] STS_LATCH_RESET = 16'h0000;
  // Collision test timing: bit time at 100 Mbps, 10 ns
  localparam int BIT_TIME_NS = 10;
  localparam int CLK_PERIOD_NS = 20;
  localparam int COL_DEASSERT_BITS = 4;
  localparam int COL_OFF_CYC_RAW = COL_DEASSERT_BITS * BIT_TIME_NS
    / CLK_PERIOD_NS;
  localparam int COL_OFF_CYC = (COL_OFF_CYC_RAW < 1) ? 1 : COL_OFF_CYC_RAW;
  localparam logic [2:0] COL_OFF_CNT = 3'(COL_OFF_CYC);
endpackage

// File: pcs_sync3.sv
module pcs_sync3
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      stage_r <= 3'h0;
    else
      stage_r <= {stage_r[1:0], din};
  end
  // Change accepted once second and third stages agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dout <= 1'b0;
    else if (stage_r[1] == stage_r[2])
      dout <= stage_r[2];
  end
endmodule

// File: pcs_latch_bit.sv
module pcs_latch_bit
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear_default,
  input wire logic live,
  input wire logic read_ack,
  input wire logic active_high,
  output logic value
);
  logic held_r;
  logic event_now;
  logic default_v;
  assign event_now = active_high ? live : ~live;
  // Every latched status bit defaults to zero, the latch-low link bit too
  assign default_v = 1'b0;
  // Event wins over the clear done by a read
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      held_r <= 1'b0;
    else if (clear_default)
      held_r <= 1'b0;
    else if (event_now)
      held_r <= 1'b1;
    else if (read_ack)
      held_r <= 1'b0;
  end
  assign value = held_r ? active_high : (clear_default ? default_v : live);
endmodule

// File: pcs_regs.sv
module pcs_regs
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic [4:0] phy_addr,
  input wire logic strap_config_select,
  input wire logic duplex_select_pin,
  input wire logic an_enable_pin,
  input wire logic rate_select_pin,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic override_writable,
  input wire logic an_started,
  input wire logic an_complete,
  input wire logic an_duplex,
  input wire logic an_rate,
  input wire logic remote_fault,
  input wire logic link_up,
  input wire logic jabber,
  output logic an_restart,
  output logic loopback_en,
  output logic full_duplex,
  output logic speed_100,
  output logic low_power,
  output logic tx_pair_tristate,
  output logic tx_pair_pos_oe,
  output logic tx_pair_neg_oe,
  input wire logic tx_pair_pos_in,
  input wire logic tx_pair_neg_in,
  output logic tx_pair_pos,
  output logic tx_pair_neg,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic [3:0] txd,
  output logic tx_en_int,
  output logic tx_er_int,
  output logic [3:0] txd_int,
  input wire logic mii_col_in,
  input wire logic mii_crs_in,
  input wire logic mii_rx_dv_in,
  input wire logic mii_rx_er_in,
  input wire logic [3:0] mii_rxd_in,
  input wire logic mii_tx_clk_in,
  input wire logic mii_rx_clk_in,
  output logic col,
  output logic crs,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  output logic tx_clk,
  output logic rx_clk,
  output logic mii_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Control register
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  logic [15:0] ovr_r;
  logic [15:0] ovr_nxt;
  logic strap_done_r;
  logic wr_ctl;
  logic wr_sts;
  logic rd_sts;
  logic soft_an_en;
  logic restart_req;
  logic lp_enter;
  logic low_power_q_r;
  logic hw_mode;
  logic an_active;
  logic isolate;
  logic duplex_sel_s;
  logic an_en_pin_s;
  logic rate_sel_s;
  logic tx_en_s;

  function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] r);
    addr_hit = (a == r);
  endfunction

  assign wr_ctl = reg_wr && addr_hit(reg_addr, REG_CONTROL);
  assign wr_sts = reg_wr && addr_hit(reg_addr, REG_BASIC_STATUS);
  assign rd_sts = reg_rd && addr_hit(reg_addr, REG_BASIC_STATUS);
  assign hw_mode = ~strap_config_select;
  assign soft_an_en = ctl_r[CTL_AN_EN];
  assign an_active = hw_mode ? an_en_pin_s : soft_an_en;
  assign restart_req = wr_ctl && reg_wdata[CTL_AN_RESTART]
    && an_active;

  pcs_sync3 u_sync_dpx
  (
    .clock(clock),
    .rst_n(rst_n),
    .din(duplex_select_pin),
    .dout(duplex_sel_s)
  );
  pcs_sync3 u_sync_an
  (
    .clock(clock),
    .rst_n(rst_n),
    .din(an_enable_pin),
    .dout(an_en_pin_s)
  );
  pcs_sync3 u_sync_rate
  (
    .clock(clock),
    .rst_n(rst_n),
    .din(rate_select_pin),
    .dout(rate_sel_s)
  );
  pcs_sync3 u_sync_txen
  (
    .clock(clock),
    .rst_n(rst_n),
    .din(tx_en),
    .dout(tx_en_s)
  );

  always_comb
  begin
    ctl_nxt = ctl_r;
    if (wr_ctl)
    begin
      ctl_nxt[CTL_LOOPBACK:CTL_COL_TEST] = reg_wdata[CTL_LOOPBACK:CTL_COL_TEST];
      ctl_nxt[CTL_AN_RESTART] = restart_req;
    end
    if (an_started)
      ctl_nxt[CTL_AN_RESTART] = 1'b0;
    ctl_nxt[CTL_COL_TEST-1:0] = '0;
    ctl_nxt[15] = 1'b0;
  end

  always_comb
  begin
    ovr_nxt = ovr_r;
    if (wr_sts && override_writable)
      ovr_nxt = (reg_wdata & STS_OVR_MASK) | (ovr_r & ~STS_OVR_MASK);
  end

  // Isolate default depends on the address strap, caught after release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= CTL_RESET_VAL;
      ovr_r <= STS_RESET_VAL;
      strap_done_r <= 1'b0;
      low_power_q_r <= 1'b0;
    end
    else if (soft_reset || !strap_done_r)
    begin
      ctl_r <= CTL_RESET_VAL;
      ctl_r[CTL_ISOLATE] <= (phy_addr == PHY_ADDR_ISOLATE);
      ovr_r <= STS_RESET_VAL;
      strap_done_r <= 1'b1;
      low_power_q_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      ovr_r <= ovr_nxt;
      low_power_q_r <= ctl_r[CTL_LOW_POWER];
    end
  end

  assign an_restart = ctl_r[CTL_AN_RESTART];
  assign low_power = ctl_r[CTL_LOW_POWER];
  assign lp_enter = (low_power && !low_power_q_r) || soft_reset
    || !strap_done_r;
  assign isolate = ctl_r[CTL_ISOLATE];
  assign loopback_en = ctl_r[CTL_LOOPBACK];

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode selection
  logic duplex_mode;
  logic rate_mode;
  // Loopback with manual duplex falls back to half duplex
  assign duplex_mode = hw_mode ? duplex_sel_s :
    soft_an_en ? an_duplex :
    loopback_en ? 1'b0 :
    ctl_r[CTL_DUPLEX];
  assign rate_mode = hw_mode ? rate_sel_s :
    soft_an_en ? an_rate : ctl_r[CTL_RATE];

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_duplex <= 1'b0;
      speed_100 <= 1'b0;
    end
    else
    begin
      full_duplex <= duplex_mode;
      speed_100 <= rate_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register with latching bits
  logic an_done_v;
  logic rfault_v;
  logic link_v;
  logic jabber_v;
  logic [15:0] sts_word;

  pcs_latch_bit u_an_done
  (
    .clock(clock),
    .rst_n(rst_n),
    .clear_default(lp_enter),
    .live(an_complete && an_active),
    .read_ack(rd_sts),
    .active_high(1'b1),
    .value(an_done_v)
  );
  pcs_latch_bit u_rfault
  (
    .clock(clock),
    .rst_n(rst_n),
    .clear_default(lp_enter),
    .live(remote_fault),
    .read_ack(rd_sts),
    .active_high(1'b1),
    .value(rfault_v)
  );
  pcs_latch_bit u_link
  (
    .clock(clock),
    .rst_n(rst_n),
    .clear_default(lp_enter),
    .live(link_up),
    .read_ack(rd_sts),
    .active_high(1'b0),
    .value(link_v)
  );
  pcs_latch_bit u_jabber
  (
    .clock(clock),
    .rst_n(rst_n),
    .clear_default(lp_enter),
    .live(jabber),
    .read_ack(rd_sts),
    .active_high(1'b1),
    .value(jabber_v)
  );

  always_comb
  begin
    sts_word = ovr_r & STS_OVR_MASK;
    sts_word[STS_T4] = 1'b0;
    sts_word[STS_AN_DONE] = an_done_v;
    sts_word[STS_RFAULT] = rfault_v;
    sts_word[STS_AN_ABLE] = 1'b1;
    sts_word[STS_LINK] = link_v;
    sts_word[STS_JABBER] = jabber_v;
    sts_word[STS_EXT_CAP] = 1'b1;
  end

  // Reads are served regardless of isolate or low power
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= addr_hit(reg_addr, REG_CONTROL) ? ctl_r :
        addr_hit(reg_addr, REG_BASIC_STATUS) ? sts_word : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Collision test
  logic [2:0] col_off_r;
  logic col_test_r;
  logic col_drive;
  // TXEN rise shows after sync delay, well inside 512 bit times
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_off_r <= 3'h0;
      col_test_r <= 1'b0;
    end
    else if (!ctl_r[CTL_COL_TEST])
    begin
      col_off_r <= 3'h0;
      col_test_r <= 1'b0;
    end
    else if (tx_en_s && !isolate)
    begin
      col_off_r <= COL_OFF_CNT;
      col_test_r <= 1'b1;
    end
    else if (col_off_r > 3'h1)
      col_off_r <= col_off_r - 3'h1;
    else
    begin
      col_off_r <= 3'h0;
      col_test_r <= 1'b0;
    end
  end
  // Raw TXEN gates the fall: the synchroniser alone is too slow for it
  assign col_drive = ctl_r[CTL_COL_TEST] ? (col_test_r & tx_en)
    : (loopback_en ? 1'b0 : mii_col_in);

  ////////////////////////////////////////////////////////////////////////////
  // MII and line pins
  logic gate;
  assign gate = ~low_power;
  // Low power drives zero; isolate releases the pins instead
  assign mii_oe = ~isolate;
  assign col = col_drive & gate;
  assign crs = mii_crs_in & gate;
  assign rx_dv = mii_rx_dv_in & gate;
  assign rx_er = mii_rx_er_in & gate;
  assign rxd = mii_rxd_in & {4{gate}};
  assign tx_clk = mii_tx_clk_in & gate;
  assign rx_clk = mii_rx_clk_in & gate;
  assign tx_en_int = tx_en & ~isolate & gate;
  assign tx_er_int = tx_er & ~isolate & gate;
  assign txd_int = txd & {4{~isolate & gate}};
  assign tx_pair_tristate = low_power;
  assign tx_pair_pos_oe = ~low_power;
  assign tx_pair_neg_oe = ~low_power;
  assign tx_pair_pos = tx_pair_pos_in & gate;
  assign tx_pair_neg = tx_pair_neg_in & gate;
endmodule

// File: pcs_regs_monitor.sv
module pcs_regs_monitor
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic strap_config_select,
  input wire logic duplex_select_pin,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic an_started,
  input wire logic remote_fault,
  input wire logic an_restart,
  input wire logic full_duplex,
  input wire logic low_power,
  input wire logic tx_pair_tristate,
  input wire logic tx_pair_pos_oe,
  input wire logic tx_pair_neg_oe,
  input wire logic col,
  input wire logic rx_dv,
  input wire logic mii_oe,
  input wire logic tx_en_int,
  input wire logic [3:0] txd_int
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  chk_lp_outputs: assert property (
    low_power |-> !col && !rx_dv)
    else $error("mii outputs not low in low power");
  chk_lp_tristate: assert property (
    low_power |-> tx_pair_tristate && !tx_pair_pos_oe && !tx_pair_neg_oe)
    else $error("tx pair driven in low power");
  chk_iso_inputs: assert property (
    !mii_oe |-> !tx_en_int && txd_int == 4'h0)
    else $error("mii inputs pass while isolated");
  chk_ctl_reserved: assert property (
    reg_rd && reg_addr == REG_CONTROL |=> reg_rdata[6:0] == 7'h00)
    else $error("reserved control bits not zero");
  chk_t4_zero: assert property (
    reg_rd && reg_addr == REG_BASIC_STATUS |=> !reg_rdata[STS_T4])
    else $error("t4 ability bit set");
  chk_cap_ones: assert property (
    reg_rd && reg_addr == REG_BASIC_STATUS
    |=> reg_rdata[STS_AN_ABLE] && reg_rdata[STS_EXT_CAP])
    else $error("fixed ability bits not one");
  chk_restart_clear: assert property (
    an_restart && an_started |-> ##[1:4] !an_restart)
    else $error("restart bit did not clear");
  // Pin passes a synchroniser, so only a long stable stretch is judged
  chk_hw_duplex: assert property (
    ($stable(duplex_select_pin) && !strap_config_select)[*8]
    |-> full_duplex == duplex_select_pin)
    else $error("hardware duplex not from pin");
  chk_rfault_latch: assert property (
    reg_rd && reg_addr == REG_BASIC_STATUS && $past(remote_fault)
    && !low_power |=> reg_rdata[STS_RFAULT])
    else $error("remote fault event lost");
endmodule
////////////////////////////////////////////////////////////////////////////
bind pcs_regs pcs_regs_monitor chk_u (.clock, .rst_n, .strap_config_select,
  .duplex_select_pin, .reg_rd, .reg_addr, .reg_rdata, .an_started,
  .remote_fault, .an_restart, .full_duplex, .low_power, .tx_pair_tristate,
  .tx_pair_pos_oe, .tx_pair_neg_oe, .col, .rx_dv, .mii_oe, .tx_en_int,
  .txd_int);

// File: pcs_mac_model.sv
module pcs_mac_model
  import pcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic send,
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] txd
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_en <= 1'b0;
      tx_er <= 1'b0;
      txd <= 4'h0;
    end
    else
    begin
      tx_en <= send;
      tx_er <= 1'b0;
      // Idle nibble flips each cycle so stale data never looks valid
      txd <= send ? txd + 4'h1 : ~txd;
    end
  end
endmodule

// File: tb_phy_control_status_regs.sv
module tb_phy_control_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import pcs_pkg::*;
  logic clock, rst_n, strap, dpx, anp, reg_wr, reg_rd, ovr, ans, anc, andp;
  logic remote_fault, send, tpi;
  logic [4:0] pa, reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0] rxv;
  logic an_restart, full_duplex, speed_100, low_power, tpt, poe, noe, tpp;
  logic tpn, tx_en, tx_er, col, crs, rx_dv, mii_oe;
  logic [3:0] txd, rxd;
  logic srst, rx_er, tx_clk, rx_clk;
  logic [19:0] rows [7];
  int bad_count, num_checks, i;
  always #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  pcs_regs dut_u (.clock, .rst_n, .soft_reset(srst), .phy_addr(pa),
    .strap_config_select(strap), .duplex_select_pin(dpx),
    .an_enable_pin(anp), .rate_select_pin(1'b0), .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .override_writable(ovr),
    .an_started(ans), .an_complete(anc), .an_duplex(andp), .an_rate(1'b0),
    .remote_fault, .link_up(1'b0), .jabber(1'b0), .an_restart,
    .loopback_en(), .full_duplex, .speed_100, .low_power,
    .tx_pair_tristate(tpt), .tx_pair_pos_oe(poe), .tx_pair_neg_oe(noe),
    .tx_pair_pos_in(tpi), .tx_pair_neg_in(tpi), .tx_pair_pos(tpp),
    .tx_pair_neg(tpn), .tx_en, .tx_er, .txd, .tx_en_int(), .tx_er_int(),
    .txd_int(), .mii_col_in(rxv[0]), .mii_crs_in(rxv[1]),
    .mii_rx_dv_in(rxv[2]), .mii_rx_er_in(rxv[3]), .mii_rxd_in(rxv[7:4]),
    .mii_tx_clk_in(rxv[8]), .mii_rx_clk_in(rxv[9]), .col, .crs, .rx_dv,
    .rx_er, .rxd, .tx_clk, .rx_clk, .mii_oe);
  pcs_mac_model mac_u (.clock, .rst_n, .send, .tx_en, .tx_er, .txd);
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task ck(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ck1(input logic got, input logic exp);
    ck({15'h0, got}, {15'h0, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Reserved bits are always written as zero by every caller
  task write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task read_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    ck(reg_rdata, exp);
  endtask
  task wait_col(input logic v);
    #1;
    for (i = 0; i < 12 && col !== v; i++)
      cyc(1);
    ck({15'h0, col}, {15'h0, v});
    if (col !== v)
      wrap_up();
  endtask
  task do_reset(input logic [4:0] a);
    @(posedge clock);
    rst_n <= 1'b0;
    pa <= a;
    cyc(2);
    @(posedge clock) rst_n <= 1'b1;
    cyc(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clock, rst_n, strap, dpx, anp, reg_wr, reg_rd, ovr, ans, anc} = '0;
    {andp, remote_fault, send, tpi, srst, pa, reg_addr, reg_wdata, rxv} = '0;
    // Packed as strap, pin, negotiated duplex, expected duplex, control
    rows = '{20'h90100, 20'he0000, 20'hb1000, 20'h81100, 20'h84100,
      20'h50000, 20'h00100};
    do_reset(5'h00);
    @(posedge clock) send <= 1'b1;
    read_reg(REG_CONTROL, 16'h3400);
    read_reg(REG_BASIC_STATUS, STS_RESET_VAL);
    ck({15'h0, mii_oe}, 16'h0000);
    do_reset(5'h03);
    read_reg(REG_CONTROL, CTL_RESET_VAL);
    ck({15'h0, mii_oe}, 16'h0001);
    $display("test reset done");
    @(posedge clock) ovr <= 1'b1;
    send <= 1'b0;
    // Reserved bits 10:7 stay at their zero default; bit 15 is not reserved
    write_reg(REG_BASIC_STATUS, 16'hf87f);
    read_reg(REG_BASIC_STATUS, 16'h7849);
    write_reg(REG_BASIC_STATUS, 16'h0000);
    read_reg(REG_BASIC_STATUS, 16'h0009);
    write_reg(REG_BASIC_STATUS, STS_RESET_VAL);
    @(posedge clock) ovr <= 1'b0;
    write_reg(REG_BASIC_STATUS, 16'h0000);
    read_reg(REG_BASIC_STATUS, STS_RESET_VAL);
    read_reg(5'h1f, 16'h0000);
    $display("test status done");
    @(posedge clock) strap <= 1'b1;
    write_reg(REG_CONTROL, 16'h0000);
    write_reg(REG_CONTROL, 16'h0200);
    read_reg(REG_CONTROL, 16'h0000);
    write_reg(REG_CONTROL, 16'h1000);
    write_reg(REG_CONTROL, 16'h1200);
    cyc(1);
    ck({15'h0, an_restart}, 16'h0001);
    @(posedge clock) ans <= 1'b1;
    cyc(4);
    read_reg(REG_CONTROL, 16'h1000);
    @(posedge clock) ans <= 1'b0;
    $display("test restart done");
    foreach (rows[k])
    begin
      @(posedge clock);
      strap <= rows[k][19];
      dpx <= rows[k][18];
      andp <= rows[k][17];
      write_reg(REG_CONTROL, rows[k][15:0]);
      cyc(8);
      ck1(full_duplex, rows[k][16]);
    end
    @(posedge clock) strap <= 1'b1;
    write_reg(REG_CONTROL, 16'h2000);
    cyc(8);
    ck({15'h0, speed_100}, 16'h0001);
    $display("test duplex done");
    // Negotiation must be on, or the complete bit never sets
    write_reg(REG_CONTROL, 16'h1000);
    for (int j = 0; j < 2; j++)
    begin
      @(posedge clock);
      remote_fault <= (j == 0);
      anc <= (j == 1);
      // Read lands on the edge right after the one-cycle event
      @(posedge clock);
      remote_fault <= 1'b0;
      anc <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= REG_BASIC_STATUS;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      ck(reg_rdata, STS_RESET_VAL | (16'h10 << j));
      read_reg(REG_BASIC_STATUS, STS_RESET_VAL);
    end
    $display("test latch done");
    write_reg(REG_CONTROL, 16'h4080);
    @(posedge clock) send <= 1'b1;
    wait_col(1'b1);
    @(posedge clock) send <= 1'b0;
    wait_col(1'b0);
    write_reg(REG_CONTROL, 16'h0000);
    @(posedge clock) send <= 1'b1;
    cyc(12);
    ck({15'h0, col}, 16'h0000);
    @(posedge clock) send <= 1'b0;
    $display("test collision done");
    @(posedge clock) remote_fault <= 1'b1;
    tpi <= 1'b1;
    rxv <= 10'h3ff;
    @(posedge clock) remote_fault <= 1'b0;
    #1;
    ck({6'h0, rx_er, tx_clk, rx_clk, col, crs, rx_dv, rxd},
      16'h03ff);
    write_reg(REG_CONTROL, 16'h0800);
    cyc(2);
    ck({rx_er, tx_clk, rx_clk, low_power, tpt, poe, noe, tpp, tpn, col,
      crs, rx_dv, rxd}, 16'h1800);
    read_reg(REG_BASIC_STATUS, STS_RESET_VAL);
    read_reg(REG_CONTROL, 16'h0800);
    write_reg(REG_CONTROL, 16'h0000);
    cyc(2);
    ck({14'h0, poe, tpp}, 16'h0003);
    $display("test low power done");
    write_reg(REG_CONTROL, 16'h0180);
    @(posedge clock) srst <= 1'b1;
    @(posedge clock) srst <= 1'b0;
    read_reg(REG_CONTROL, CTL_RESET_VAL);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
